//--- src/qec_pkg.sv
package qec_pkg;

  localparam int unsigned CNT_W = 24;
  localparam int unsigned NSW = 8;
  localparam int unsigned NDOUT = 7;
  localparam int unsigned NDIN = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_OVR = 8'h08;
  localparam logic [7:0] OFF_MAX = 8'h0C;
  localparam logic [7:0] OFF_TBASE = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_DIN = 8'h18;
  localparam logic [7:0] OFF_DOUT = 8'h1C;
  localparam logic [7:0] OFF_SP = 8'h20;
  localparam logic [7:0] OFF_SP_END = 8'h5C;

  localparam int unsigned CTRL_MASK_BIT = 0;
  localparam int unsigned CTRL_CRST_BIT = 1;
  localparam int unsigned CTRL_EN_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h4;
  localparam logic [CNT_W-1:0] MAX_RST = 24'hFFFFFF;
  localparam logic [31:0] TBASE_RST = 32'h00000000;

  // Configuration word layout: merge [6:0], pol 7, phase 8, clk 9, negate [17:10]
  localparam int unsigned CFG_W = 18;
  typedef struct packed {
    logic [NSW-1:0] negate;
    logic clk_int;
    logic m_phase_hi;
    logic m_pol_low;
    logic [NSW-2:0] merge;
  } qec_cfg_t;
  localparam qec_cfg_t CFG_RST = 18'h00000;

  typedef struct packed {
    logic [CNT_W-1:0] lo;
    logic [CNT_W-1:0] hi;
  } qec_sp_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TB_RES_NS = 1000;
  localparam int unsigned CYC_PER_US = TB_RES_NS / CLK_PERIOD_NS;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : qec_pkg

//--- src/qec_top.sv
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module qec_top
  import qec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_marker_i,
  input wire logic enc_marker_dis_i,
  input wire logic [qec_pkg::NDIN-1:0] gp_in_i,
  output logic [qec_pkg::NSW-1:0] cam_o,
  output logic [qec_pkg::NDOUT-1:0] dout_o
);
  import qec_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] qec_gray_next(input logic [1:0] ab);
    unique case (ab)
      2'h0: qec_gray_next = 2'h2;
      2'h2: qec_gray_next = 2'h3;
      2'h3: qec_gray_next = 2'h1;
      2'h1: qec_gray_next = 2'h0;
    endcase
  endfunction : qec_gray_next

  function automatic logic qec_window(input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] lo,
                                      input logic [CNT_W-1:0] hi,
                                      input logic [CNT_W-1:0] mx);
    logic [CNT_W-1:0] eff_hi;
    eff_hi = (mx < hi) ? mx : hi;
    qec_window = (lo <= mx) && (cnt >= lo) && (cnt <= eff_hi);
  endfunction : qec_window

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int unsigned SYN_W = NDIN + 4;
  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;
  logic [SYN_W-1:0] syn_in;
  assign syn_in = {gp_in_i, enc_marker_dis_i, enc_marker_i, enc_b_i, enc_a_i};

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      syn1_r <= '0;
      syn2_r <= '0;
    end
    else
    begin
      syn1_r <= syn_in;
      syn2_r <= syn1_r;
    end
  end

  logic a_s;
  logic b_s;
  logic m_s;
  logic mdis_s;
  logic [NDIN-1:0] din_s;
  assign a_s = syn2_r[0];
  assign b_s = syn2_r[1];
  assign m_s = syn2_r[2];
  assign mdis_s = syn2_r[3];
  assign din_s = syn2_r[SYN_W-1:4];

  // ----------------------------------------
  // AHB-Lite register file
  // ----------------------------------------
  logic [2:0] ctrl_r, ctrl_nxt;
  qec_cfg_t cfg_r, cfg_nxt;
  qec_cfg_t ovr_r, ovr_nxt;
  logic [CNT_W-1:0] max_r, max_nxt;
  logic [31:0] tbase_r, tbase_nxt;
  logic [NDOUT-1:0] dout_r, dout_nxt;
  qec_sp_t [NSW-1:0] sp_r, sp_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  logic addr_ph;
  logic [7:0] a_off;
  logic [2:0] sp_idx;
  assign addr_ph = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign a_off = haddr_i[7:0];
  assign sp_idx = wr_addr_r[5:3] - 3'h4;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    ovr_nxt = ovr_r;
    max_nxt = max_r;
    tbase_nxt = tbase_r;
    dout_nxt = dout_r;
    sp_nxt = sp_r;
    wr_pend_nxt = addr_ph && hwrite_i;
    wr_addr_nxt = addr_ph ? a_off : wr_addr_r;
    rdata_nxt = 32'h00000000;
    if (wr_pend_r)
    begin
      if (wr_addr_r == OFF_CTRL)
        ctrl_nxt = hwdata_i[2:0];
      else if (wr_addr_r == OFF_CFG)
        cfg_nxt = hwdata_i[CFG_W-1:0];
      else if (wr_addr_r == OFF_OVR)
        ovr_nxt = hwdata_i[CFG_W-1:0];
      else if (wr_addr_r == OFF_MAX)
        max_nxt = hwdata_i[CNT_W-1:0];
      else if (wr_addr_r == OFF_TBASE)
        tbase_nxt = hwdata_i;
      else if (wr_addr_r == OFF_DOUT)
        dout_nxt = hwdata_i[NDOUT-1:0];
      else if (wr_addr_r >= OFF_SP && wr_addr_r <= OFF_SP_END && wr_addr_r[1:0] == 2'h0)
      begin
        if (wr_addr_r[2])
          sp_nxt[sp_idx].hi = hwdata_i[CNT_W-1:0];
        else
          sp_nxt[sp_idx].lo = hwdata_i[CNT_W-1:0];
      end
    end
    // Read data registered in the address phase, zero wait states
    if (addr_ph && !hwrite_i)
    begin
      if (a_off == OFF_CTRL)
        rdata_nxt = {29'h0, ctrl_r};
      else if (a_off == OFF_CFG)
        rdata_nxt = {14'h0, cfg_r};
      else if (a_off == OFF_OVR)
        rdata_nxt = {14'h0, ovr_r};
      else if (a_off == OFF_MAX)
        rdata_nxt = {8'h00, max_r};
      else if (a_off == OFF_TBASE)
        rdata_nxt = tbase_r;
      else if (a_off == OFF_COUNT)
        rdata_nxt = {8'h00, cnt_r};
      else if (a_off == OFF_DIN)
        rdata_nxt = {24'h0, din_s};
      else if (a_off == OFF_DOUT)
        rdata_nxt = {25'h0, dout_r};
      else if (a_off >= OFF_SP && a_off <= OFF_SP_END && a_off[1:0] == 2'h0)
        rdata_nxt = a_off[2] ? {8'h00, sp_r[a_off[5:3] - 3'h4].hi}
                             : {8'h00, sp_r[a_off[5:3] - 3'h4].lo};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= CTRL_RST;
      cfg_r <= CFG_RST;
      ovr_r <= CFG_RST;
      max_r <= MAX_RST;
      tbase_r <= TBASE_RST;
      dout_r <= '0;
      sp_r <= '0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      ovr_r <= ovr_nxt;
      max_r <= max_nxt;
      tbase_r <= tbase_nxt;
      dout_r <= dout_nxt;
      sp_r <= sp_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Active configuration
  // ----------------------------------------
  qec_cfg_t act;
  assign act = ctrl_r[CTRL_MASK_BIT] ? ovr_r : cfg_r;

  // ----------------------------------------
  // Time base and position counter
  // ----------------------------------------
  logic [6:0] us_r, us_nxt;
  logic [31:0] tb_r, tb_nxt;
  logic [1:0] ab_r, ab_nxt;
  logic step_up;
  logic step_dn;
  logic a_edge;
  logic mark_ok;
  logic tick;
  logic [1:0] ab_now;

  assign ab_now = {a_s, b_s};
  assign step_up = !act.clk_int && (ab_now == qec_gray_next(ab_r));
  assign step_dn = !act.clk_int && (ab_r == qec_gray_next(ab_now));
  assign a_edge = a_s ^ ab_r[1];
  assign mark_ok = (m_s ^ act.m_pol_low) && !mdis_s && (b_s == act.m_phase_hi);
  assign tick = act.clk_int && (us_r == 7'(CYC_PER_US - 1)) && (tb_r == tbase_r);

  always_comb
  begin
    ab_nxt = ab_now;
    us_nxt = (us_r == 7'(CYC_PER_US - 1)) ? 7'h00 : us_r + 7'h01;
    tb_nxt = tb_r;
    if (us_r == 7'(CYC_PER_US - 1))
      tb_nxt = (tb_r == tbase_r) ? 32'h00000000 : tb_r + 32'h00000001;
    cnt_nxt = cnt_r;
    // clearing the enable bit stops counting; the reset bit overrides it and holds the count at zero
    if (ctrl_r[CTRL_EN_BIT])
    begin
      // zero on marker with A edge
      if (!act.clk_int && mark_ok && a_edge && (step_up || step_dn))
        cnt_nxt = '0;
      else if (step_up || tick)
        cnt_nxt = (cnt_r >= max_r) ? '0 : cnt_r + 24'h000001;
      else if (step_dn)
        cnt_nxt = (cnt_r == '0 || cnt_r > max_r) ? max_r : cnt_r - 24'h000001;
    end
    if (ctrl_r[CTRL_CRST_BIT])
      cnt_nxt = '0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ab_r <= 2'h0;
      us_r <= 7'h00;
      tb_r <= 32'h00000000;
      cnt_r <= '0;
    end
    else
    begin
      ab_r <= ab_nxt;
      us_r <= us_nxt;
      tb_r <= tb_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Cam windows and merging
  // ----------------------------------------
  logic [NSW-1:0] win;
  logic [NSW-1:0] cam_nxt;
  logic [NSW-1:0] cam_r;
  logic [NSW-1:0] mrg;
  logic acc;

  // Top channel never merges onward, so its merge bit is a constant zero
  assign mrg = {1'b0, act.merge};

  always_comb
  begin
    acc = 1'b0;
    win = '0;
    cam_nxt = '0;
    for (int i = 0; i < NSW; i++)
    begin
      win[i] = qec_window(cnt_r, sp_r[i].lo, sp_r[i].hi, max_r);
      acc = acc | win[i];
      if (mrg[i])
        cam_nxt[i] = 1'b0;
      else
      begin
        cam_nxt[i] = acc ^ act.negate[i];
        acc = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      cam_r <= '0;
    else
      cam_r <= cam_nxt;
  end

  assign cam_o = cam_r;
  assign dout_o = dout_r;
  assign hrdata_o = rdata_r;
  // Zero wait states: every transfer ends after one data cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_up_step;
    step_up && ctrl_r[CTRL_EN_BIT] && !ctrl_r[CTRL_CRST_BIT] && !(mark_ok && a_edge);
  endsequence

  chk_count_up_step: assert property (
    (s_up_step and (cnt_r < max_r)) |=> cnt_r == $past(cnt_r) + 24'h000001)
    else $error("up step did not add one");

  chk_count_dn_step: assert property (
    step_dn && ctrl_r[CTRL_EN_BIT] && !ctrl_r[CTRL_CRST_BIT] && !(mark_ok && a_edge)
      && cnt_r != '0 && cnt_r <= max_r |=> cnt_r == $past(cnt_r) - 24'h000001)
    else $error("down step did not subtract one");

  chk_count_wrap: assert property (
    (s_up_step and (cnt_r == max_r)) |=> cnt_r == '0)
    else $error("counter did not wrap at maximum");

  chk_marker_zero: assert property (
    ctrl_r[CTRL_EN_BIT] && mark_ok && a_edge && step_up |=> cnt_r == '0)
    else $error("marker did not zero counter");

  chk_marker_dis: assert property (
    mdis_s |-> !mark_ok)
    else $error("marker seen while disabled");

  chk_host_reset: assert property (
    ctrl_r[CTRL_CRST_BIT] |=> cnt_r == '0)
    else $error("counter not held at zero");

  chk_held_disabled: assert property (
    !ctrl_r[CTRL_EN_BIT] && !ctrl_r[CTRL_CRST_BIT] |=> $stable(cnt_r))
    else $error("counter moved while disabled");

  chk_cam_follow: assert property (
    cam_nxt != cam_r |=> cam_o == $past(cam_nxt))
    else $error("cam output did not follow window");

  chk_top_channel: assert property (
    &act.merge[NSW-2:0] && !act.negate[NSW-1] |-> ##1 cam_o[NSW-1] == $past(|win))
    else $error("all merged windows not on top channel");

  chk_unmerged_out: assert property (
    act.merge == '0 |-> cam_nxt == (win ^ act.negate))
    else $error("unmerged channel not own window");

  chk_no_window: assert property (
    sp_r[0].lo > max_r |-> !win[0])
    else $error("window active above maximum");

endmodule : qec_top

//--- tb/qec_enc_model.sv
`timescale 1ns/10ps
module qec_enc_model (
  input wire logic clk_sys_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic mk_en_i,
  input wire logic mk_low_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_marker_o
);
  // ----------------------------------------
  // Gray phase, AB = 00 10 11 01 forward
  // ----------------------------------------
  logic [1:0] ph_r = 2'h0;

  always @(posedge clk_sys_i)
  begin
    if (step_i)
      ph_r <= dir_i ? ph_r + 2'h1 : ph_r - 2'h1;
  end

  assign enc_a_o = ph_r[1] ^ ph_r[0];
  assign enc_b_o = ph_r[1];
  // marker follows B
  // Marker spans the B-high half, so only one A edge falls inside it
  assign enc_marker_o = (mk_en_i & ph_r[1]) ^ mk_low_i;
endmodule : qec_enc_model

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import qec_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hready, hresp, step, dir, mk_en, mk_low, mk_dis;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q, c1;
  logic [7:0] gp_in, cam_o;
  logic [6:0] dout_o;
  logic a, b, mk;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  qec_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .enc_a_i(a), .enc_b_i(b), .enc_marker_i(mk), .enc_marker_dis_i(mk_dis),
    .gp_in_i(gp_in), .cam_o(cam_o), .dout_o(dout_o));

  qec_enc_model enc (.clk_sys_i(clk_sys_i), .step_i(step), .dir_i(dir), .mk_en_i(mk_en),
    .mk_low_i(mk_low), .enc_a_o(a), .enc_b_o(b), .enc_marker_o(mk));

  // ----------------------------------------
  // Report and hang guard
  // ----------------------------------------
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ----------------------------------------
  // Bus and encoder tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, ad};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0);
    chk(q, e);
  endtask : rd_chk

  // Seven-cycle spacing keeps every A/B level above the three-cycle minimum
  task automatic mv(input logic d, input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      step <= 1'b1;
      dir <= d;
      @(posedge clk_sys_i);
      step <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
    end
    repeat (2) @(posedge clk_sys_i);
  endtask : mv

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial
  begin
    {hsel, hwrite, step, mk_en, mk_low, mk_dis} = 6'h00;
    dir = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    gp_in = 8'hA5;
    repeat (16) @(posedge clk_sys_i);
    rst_n <= 1'b1;
    rd_chk(8'h00, 32'h4);
    rd_chk(8'h0C, 32'hFFFFFF);
    rd_chk(8'h60, 32'h0);
    rd_chk(8'h18, 32'hA5);
    wr(8'h1C, 32'h7F);
    rd_chk(8'h1C, 32'h7F);
    chk({25'h0, dout_o}, 32'h7F);
    chk({31'h0, hresp}, 32'h0);
    done("registers");
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h5);
    wr(8'h28, 32'hA);
    wr(8'h2C, 32'hC);
    mv(1'b1, 3);
    rd_chk(8'h14, 32'h3);
    chk({24'h0, cam_o}, 32'h01);
    mv(1'b0, 3);
    rd_chk(8'h14, 32'h0);
    mv(1'b1, 11);
    rd_chk(8'h14, 32'hB);
    chk({24'h0, cam_o}, 32'h02);
    done("counting");
    wr(8'h04, 32'h1001);
    repeat (3) @(posedge clk_sys_i);
    chk({24'h0, cam_o}, 32'h06);
    mv(1'b0, 8);
    chk({24'h0, cam_o}, 32'h06);
    wr(8'h0C, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk({24'h0, cam_o}, 32'h04);
    wr(8'h0C, 32'hFFFFFF);
    wr(8'h04, 32'h7F);
    repeat (3) @(posedge clk_sys_i);
    chk({24'h0, cam_o}, 32'h80);
    wr(8'h04, 32'h100);
    done("merge");
    mk_en <= 1'b1;
    mk_dis <= 1'b1;
    mv(1'b1, 4);
    rd_chk(8'h14, 32'h7);
    mk_dis <= 1'b0;
    mv(1'b1, 4);
    rd_chk(8'h14, 32'h0);
    wr(8'h04, 32'h180);
    mk_low <= 1'b1;
    mv(1'b1, 4);
    rd_chk(8'h14, 32'h0);
    wr(8'h04, 32'h0);
    mk_low <= 1'b0;
    mv(1'b1, 4);
    rd_chk(8'h14, 32'h4);
    mk_en <= 1'b0;
    done("marker");
    wr(8'h00, 32'h6);
    rd_chk(8'h14, 32'h0);
    wr(8'h00, 32'h4);
    mv(1'b1, 1);
    rd_chk(8'h14, 32'h1);
    wr(8'h00, 32'h0);
    mv(1'b1, 2);
    rd_chk(8'h14, 32'h1);
    done("reset_enable");
    wr(8'h08, 32'h200);
    rd_chk(8'h08, 32'h200);
    wr(8'h00, 32'h5);
    xfer(1'b0, 8'h14, 32'h0);
    c1 = q;
    repeat (1000) @(posedge clk_sys_i);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, (q - c1 >= 32'h9) && (q - c1 <= 32'hB)}, 32'h1);
    wr(8'h10, 32'h1);
    rd_chk(8'h10, 32'h1);
    xfer(1'b0, 8'h14, 32'h0);
    c1 = q;
    repeat (1000) @(posedge clk_sys_i);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, (q - c1 >= 32'h4) && (q - c1 <= 32'h6)}, 32'h1);
    wr(8'h00, 32'h4);
    xfer(1'b0, 8'h14, 32'h0);
    c1 = q;
    repeat (300) @(posedge clk_sys_i);
    rd_chk(8'h14, c1);
    done("internal_clock");
    close_out();
  end
endmodule : tb
